// ### hw/chain_pkg.sv
/*
  Constants shared by the neuron chain register command logic: register
  select codes, mode bit, reset defaults and command latencies.
  Assumes a 16-bit parallel register bus with a 4-bit register select.
*/
package chain_pkg;
  localparam int DW      = 16;
  localparam int NEURONS = 4;
  localparam int NW      = 2;
  localparam int ELEMS   = 256;
  localparam int EW      = 8;
  localparam int PW      = 8;
  localparam int LW      = 5;
  localparam int SW      = 4;
  localparam int PINS    = 24;

  localparam logic [SW-1:0] A_CONTEXT  = 4'h0;
  localparam logic [SW-1:0] A_ELEMENT  = 4'h1;
  localparam logic [SW-1:0] A_FINAL    = 4'h2;
  localparam logic [SW-1:0] A_PTR_GAP  = 4'h3;
  localparam logic [SW-1:0] A_LABEL    = 4'h4;
  localparam logic [SW-1:0] A_FIELD    = 4'h5;
  localparam logic [SW-1:0] A_FLOOR    = 4'h6;
  localparam logic [SW-1:0] A_CEIL     = 4'h7;
  localparam logic [SW-1:0] A_BC_ELEM  = 4'h8;
  localparam logic [SW-1:0] A_BC_LABEL = 4'h9;
  localparam logic [SW-1:0] A_IDENT    = 4'ha;
  localparam logic [SW-1:0] A_GLOBAL   = 4'hb;
  localparam logic [SW-1:0] A_REWIND   = 4'hc;
  localparam logic [SW-1:0] A_STATE    = 4'hd;
  localparam logic [SW-1:0] A_FLOAT    = 4'he;
  localparam logic [SW-1:0] A_TALLY    = 4'hf;

  localparam int MODE_BULK_BIT = 4;
  localparam int STAT_AMB_BIT  = 2;
  localparam int STAT_REC_BIT  = 3;
  localparam logic RW_READ     = 1'b1;

  localparam logic [DW-1:0] FLOOR_DEF  = 16'h0002;
  localparam logic [DW-1:0] CEIL_DEF   = 16'h4000;
  localparam logic [DW-1:0] GLOBAL_DEF = 16'h0001;
  localparam logic [DW-1:0] STATE_DEF  = 16'h0000;
  localparam logic [DW-1:0] CTX_DEF    = 16'h0001;
  localparam logic [DW-1:0] ALL_ONES   = 16'hffff;

  localparam logic [LW-1:0] LAT_ONE       = 5'h01;
  localparam logic [LW-1:0] LAT_FINAL     = 5'h03;
  localparam logic [LW-1:0] LAT_RACE_BASE = 5'h03;
  localparam logic [LW-1:0] LAT_RACE_STEP = 5'h04;
  localparam logic [LW-1:0] LAT_RACE_MAX  = 5'h10;
  localparam logic [LW-1:0] LAT_LABEL_RD  = 5'h03;
  localparam logic [LW-1:0] LAT_LABEL_SLOW= 5'h13;
endpackage

// ### hw/pin_sync.sv
/*
  Two-flop synchroniser for the bus and open-collector pin inputs.
  Assumes the pins are quasi-static around each strobe edge.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // Pins in, synchronised out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_out = sync_reg;
endmodule

// ### hw/exec_timer.sv
/*
  Command execution timer: holds the chain ready line low for the
  number of cycles the accepted command needs.
  Assumes start only pulses while ready is high.
*/
`timescale 1ns/100ps
module exec_timer
  import chain_pkg::*;
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  // Command start and its latency
  input  wire logic                     start,
  input  wire logic [chain_pkg::LW-1:0] cycles,
  // Chain ready
  output logic                          ready
);
  typedef enum logic {PH_IDLE, PH_RUN} phase_t;
  phase_t          phase_reg;
  logic [LW-1:0]   cnt_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= PH_IDLE;
      cnt_reg   <= '0;
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          if (start) begin
            phase_reg <= PH_RUN;
            cnt_reg   <= cycles;
          end
        end
        PH_RUN: begin
          if (cnt_reg <= LAT_ONE) begin
            phase_reg <= PH_IDLE;
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_reg - LAT_ONE;
          end
        end
        default: phase_reg <= PH_IDLE;
      endcase
    end
  end

  assign ready = (phase_reg == PH_IDLE);

  lat_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    start |-> (cycles >= LAT_ONE && cycles <= LAT_LABEL_SLOW))
    else $error("command latency outside 1..19");
  one_cycle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start && cycles == LAT_ONE) |=> !ready ##1 ready)
    else $error("single cycle command did not finish in one cycle");
  slow_label_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start && cycles == LAT_LABEL_SLOW) |=> !ready [*8])
    else $error("ready rose early on a slow command");
endmodule

// ### hw/neuron_chain_register_commands.sv
/*
  Register command decoder for a chain of pattern-matching neurons,
  with per-command execution latency and open-collector bus mixing.
  Assumes an external controller on the parallel register bus that
  releases its lines after the strobe falls; all pins are asynchronous.
*/
`timescale 1ns/100ps
module neuron_chain_register_commands
  import chain_pkg::*;
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  // Register bus from the controller
  input  wire logic                     bus_strobe,
  input  wire logic                     rw,
  input  wire logic [chain_pkg::SW-1:0] reg_sel,
  input  wire logic [chain_pkg::DW-1:0] data_in,
  output logic      [chain_pkg::DW-1:0] data_out,
  output logic      [chain_pkg::DW-1:0] data_oe,
  // Open-collector status lines
  input  wire logic                     recognized_n_in,
  output logic                          recognized_n_out,
  output logic                          recognized_n_oe,
  input  wire logic                     ambiguous_n_in,
  output logic                          ambiguous_n_out,
  output logic                          ambiguous_n_oe,
  // Chain ready
  output logic                          ready
);
  logic [PINS-1:0] pins_s;
  logic            amb_s;
  logic            rec_s;
  logic            ds_s;
  logic            rw_s;
  logic [SW-1:0]   sel_s;
  logic [DW-1:0]   din_s;
  logic            ds_d_reg;

  pin_sync #(.W(PINS)) u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin_in  ({ambiguous_n_in, recognized_n_in, bus_strobe, rw, reg_sel, data_in}),
    .pin_out (pins_s)
  );
  assign {amb_s, rec_s, ds_s, rw_s, sel_s, din_s} = pins_s;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) ds_d_reg <= 1'b0;
    else       ds_d_reg <= ds_s;
  end

  // Strobes arriving while busy are dropped, not queued
  wire accept = ds_s & ~ds_d_reg & ready;
  wire ds_fall = ~ds_s & ds_d_reg;
  wire wr = accept & (rw_s != RW_READ);
  wire rd = accept & (rw_s == RW_READ);

  logic [DW-1:0] ctx_reg;
  logic [DW-1:0] floor_reg;
  logic [DW-1:0] ceil_reg;
  logic [DW-1:0] glob_reg;
  logic [DW-1:0] state_reg;
  logic [PW-1:0] ptr_reg;
  logic [NW-1:0] cur_reg;
  logic          vec_done_reg;
  logic          stat_pend_reg;
  logic          rec_reg;
  logic          amb_reg;
  logic [DW-1:0] data_out_reg;
  logic [DW-1:0] data_oe_reg;

  wire bulk = state_reg[MODE_BULK_BIT];

  // Write decode
  wire w_ctx      = wr && sel_s == A_CONTEXT;
  wire w_elem     = wr && sel_s == A_ELEMENT;
  wire w_final    = wr && sel_s == A_FINAL && !bulk;
  wire w_ptr      = wr && sel_s == A_PTR_GAP;
  wire w_label    = wr && sel_s == A_LABEL;
  wire w_field    = wr && sel_s == A_FIELD && bulk;
  wire w_floor    = wr && sel_s == A_FLOOR;
  wire w_ceil     = wr && sel_s == A_CEIL;
  wire w_bc_elem  = wr && sel_s == A_BC_ELEM;
  wire w_bc_label = wr && sel_s == A_BC_LABEL && bulk;
  wire w_glob     = wr && sel_s == A_GLOBAL;
  wire w_rewind   = wr && sel_s == A_REWIND && bulk;
  wire w_state    = wr && sel_s == A_STATE;
  wire w_float    = wr && sel_s == A_FLOAT;
  wire w_uncommit = wr && sel_s == A_TALLY && !bulk;
  // Read decode
  wire r_elem     = rd && sel_s == A_ELEMENT;
  wire r_gap      = rd && sel_s == A_PTR_GAP && !bulk;
  wire r_label    = rd && sel_s == A_LABEL;
  wire snoop_rd   = rd && !bulk && (sel_s == A_PTR_GAP || sel_s == A_LABEL);
  wire norm_acc   = (w_elem || w_final) && !bulk;

  logic [DW-1:0] label_reg [NEURONS];
  logic [DW-1:0] gap_reg   [NEURONS];
  logic [DW-1:0] field_reg [NEURONS];
  logic [EW-1:0] cell_w    [NEURONS];
  logic [NEURONS-1:0] committed;
  logic [NEURONS-1:0] firing;
  logic [NEURONS-1:0] withdrawn_reg;
  logic [NEURONS-1:0] cand;
  logic [NEURONS-1:0] win_mask;

  for (genvar i = 0; i < NEURONS; i++) begin : g_cell
    logic [EW-1:0] mem [ELEMS];
    wire [EW-1:0] diff = (cell_w[i] > din_s[EW-1:0]) ? cell_w[i] - din_s[EW-1:0]
                                                    : din_s[EW-1:0] - cell_w[i];
    wire [DW-1:0] base = vec_done_reg ? '0 : gap_reg[i];
    wire [DW:0]   sum  = {1'b0, base} + {{(DW+1-EW){1'b0}}, diff};
    wire          pointed = (cur_reg == NW'(i));

    assign cell_w[i]    = mem[ptr_reg];
    assign committed[i] = (label_reg[i] != '0);
    assign firing[i]    = committed[i] && vec_done_reg && (gap_reg[i] < field_reg[i]);
    assign cand[i]      = firing[i] && !withdrawn_reg[i];

    // Memory has no reset; uncommit leaves it intact
    always_ff @(posedge sys_clk) begin
      if ((w_bc_elem && committed[i]) || (w_elem && bulk && pointed))
        mem[ptr_reg] <= din_s[EW-1:0];
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        label_reg[i]     <= '0;
        gap_reg[i]       <= ALL_ONES;
        field_reg[i]     <= CEIL_DEF;
        withdrawn_reg[i] <= 1'b0;
      end else begin
        if (w_uncommit)
          label_reg[i] <= '0;
        else if (w_bc_label)
          label_reg[i] <= din_s;
        else if (w_label && bulk && pointed)
          label_reg[i] <= din_s;
        if (norm_acc && committed[i])
          gap_reg[i] <= sum[DW] ? ALL_ONES : sum[DW-1:0];
        if (w_field && pointed)
          field_reg[i] <= din_s;
        if (w_final || w_uncommit)
          withdrawn_reg[i] <= 1'b0;
        else if (r_gap && win_mask[i])
          withdrawn_reg[i] <= 1'b1;
      end
    end
  end

  // Search-and-sort: least gap, then least label, among live candidates
  logic [DW-1:0] best_gap;
  logic [DW-1:0] best_label;
  logic [DW-1:0] id_and;
  logic [23:0]   tally_count;
  logic [2:0]    fire_cnt;
  logic          disagree;

  always_comb begin
    best_gap    = ALL_ONES;
    best_label  = ALL_ONES;
    id_and      = ALL_ONES;
    tally_count = '0;
    fire_cnt    = '0;
    disagree    = 1'b0;
    win_mask    = '0;
    for (int i = 0; i < NEURONS; i++) begin
      if (cand[i] && (gap_reg[i] < best_gap ||
          (gap_reg[i] == best_gap && label_reg[i] < best_label))) begin
        best_gap   = gap_reg[i];
        best_label = label_reg[i];
      end
      tally_count = tally_count + {23'h000000, committed[i]};
      fire_cnt    = fire_cnt + {2'h0, cand[i]};
    end
    for (int i = 0; i < NEURONS; i++) begin
      win_mask[i] = cand[i] && gap_reg[i] == best_gap && label_reg[i] == best_label;
      if (win_mask[i])
        id_and = id_and & DW'(i + 1);
      if (cand[i] && label_reg[i] != best_label)
        disagree = 1'b1;
    end
  end

  wire [DW-1:0] cur_id    = DW'(cur_reg) + 16'h0001;
  wire [DW-1:0] tally_rd  = bulk ? (committed[cur_reg] ? cur_id : DW'(cur_reg))
                          : (&committed ? ALL_ONES : tally_count[DW-1:0]);
  // Zero-extend before shifting; a widened inversion would set every upper bit
  wire [DW-1:0] amb_bit   = {{(DW-1){1'b0}}, ~amb_s};
  wire [DW-1:0] rec_bit   = {{(DW-1){1'b0}}, ~rec_s};
  wire [DW-1:0] status_rd = state_reg | (amb_bit << STAT_AMB_BIT)
                                      | (rec_bit << STAT_REC_BIT);

  logic [DW-1:0] rdata;
  always_comb begin
    case (sel_s)
      A_CONTEXT: rdata = {tally_count[23:16], ctx_reg[EW-1:0]};
      A_ELEMENT: rdata = {{(DW-EW){1'b0}}, cell_w[cur_reg]};
      A_PTR_GAP: rdata = bulk ? gap_reg[cur_reg] : best_gap;
      A_LABEL:   rdata = bulk ? label_reg[cur_reg] : best_label;
      A_FIELD:   rdata = field_reg[cur_reg];
      A_FLOOR:   rdata = floor_reg;
      A_CEIL:    rdata = ceil_reg;
      A_IDENT:   rdata = bulk ? cur_id : id_and;
      A_GLOBAL:  rdata = glob_reg;
      A_STATE:   rdata = status_rd;
      A_TALLY:   rdata = tally_rd;
      default:   rdata = '0;
    endcase
  end

  // Latency of the accepted command
  wire [LW-1:0] race_raw = LW'(fire_cnt) * LAT_RACE_STEP;
  wire [LW-1:0] race_lat = LAT_RACE_BASE + ((race_raw > LAT_RACE_MAX) ? LAT_RACE_MAX
                                                                       : race_raw);
  logic [LW-1:0] lat;
  always_comb begin
    lat = LAT_ONE;
    if (!bulk) begin
      if (w_final && |committed)
        lat = LAT_FINAL;
      else if (r_gap && fire_cnt != '0)
        lat = race_lat;
      else if (w_label)
        lat = rec_s ? LAT_LABEL_SLOW : LAT_ONE;
      else if (r_label)
        lat = rec_s ? LAT_LABEL_SLOW : LAT_LABEL_RD;
    end
  end

  exec_timer u_timer (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .start   (accept),
    .cycles  (lat),
    .ready   (ready)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctx_reg   <= CTX_DEF;
      state_reg <= STATE_DEF;
    end else begin
      if (w_ctx)   ctx_reg   <= din_s;
      if (w_state) state_reg <= din_s;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      floor_reg <= FLOOR_DEF;
      ceil_reg  <= CEIL_DEF;
      glob_reg  <= GLOBAL_DEF;
    end else if (w_uncommit) begin
      floor_reg <= FLOOR_DEF;
      ceil_reg  <= CEIL_DEF;
      glob_reg  <= GLOBAL_DEF;
    end else begin
      if (w_floor) floor_reg <= din_s;
      if (w_ceil)  ceil_reg  <= din_s;
      if (w_glob)  glob_reg  <= din_s;
    end
  end

  // Element and neuron pointers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_reg <= '0;
      cur_reg <= '0;
    end else begin
      if (w_final || w_uncommit)
        ptr_reg <= '0;
      else if (w_ptr)
        ptr_reg <= din_s[PW-1:0];
      else if (w_elem || r_elem)
        ptr_reg <= ptr_reg + 8'h01;
      if (w_rewind)
        cur_reg <= '0;
      else if (bulk && (w_label || r_label))
        cur_reg <= cur_reg + NW'(1);
    end
  end

  // Recognition status settles one cycle after the final element
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vec_done_reg  <= 1'b0;
      stat_pend_reg <= 1'b0;
      rec_reg       <= 1'b0;
      amb_reg       <= 1'b0;
    end else begin
      stat_pend_reg <= w_final;
      if (w_final)
        vec_done_reg <= 1'b1;
      else if (norm_acc || w_uncommit)
        vec_done_reg <= 1'b0;
      if (norm_acc || w_uncommit) begin
        rec_reg <= 1'b0;
        amb_reg <= 1'b0;
      end else if (stat_pend_reg) begin
        rec_reg <= |cand && !disagree;
        amb_reg <= |cand && disagree;
      end
    end
  end

  // Snooping reads only pull low, so several chips can wire-AND the bus
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      data_out_reg <= '0;
      data_oe_reg  <= '0;
    end else if (rd) begin
      data_out_reg <= snoop_rd ? '0 : rdata;
      data_oe_reg  <= snoop_rd ? ~rdata : ALL_ONES;
    end else if (w_float || ds_fall) begin
      data_oe_reg  <= '0;
    end
  end

  assign data_out         = data_out_reg;
  assign data_oe          = data_oe_reg;
  assign recognized_n_out = 1'b0;
  assign recognized_n_oe  = rec_reg;
  assign ambiguous_n_out  = 1'b0;
  assign ambiguous_n_oe   = amb_reg;

  float_release_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    w_float |=> data_oe == '0)
    else $error("data lines still driven after float write");
  uncommit_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    w_uncommit |=> committed == '0)
    else $error("neuron still committed after uncommit-all");
  uncommit_defaults_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    w_uncommit |=> ptr_reg == '0 && floor_reg == FLOOR_DEF && glob_reg == GLOBAL_DEF)
    else $error("pointer or defaults not restored by uncommit-all");
  tally_full_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rd && sel_s == A_TALLY && !bulk && &committed) |=> data_out == ALL_ONES)
    else $error("full chain tally not all ones");
  rewind_first_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    w_rewind |=> cur_reg == '0)
    else $error("rewind did not reach first neuron");
  bc_commit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (w_bc_label && din_s != '0) |=> &committed)
    else $error("broadcast label did not commit every neuron");
  snoop_pull_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    snoop_rd |=> data_out == '0 && data_oe == ~$past(rdata))
    else $error("snooping read not driven open-collector");
  busy_ignore_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    accept |=> !ready && !accept)
    else $error("ready high or strobe taken right after acceptance");
endmodule

// ### verification/ctrl_model.sv
/*
  Controller model for the neuron chain register bus: strobes on falling
  clock edges and resolves the pulled-up data lines.
  Assumes a free-running sys_clk and a ready line that idles high.
*/
`timescale 1ns/100ps
module ctrl_model
  import chain_pkg::*;
(
  // Clock
  input  wire logic                     sys_clk,
  // Bus towards the chain
  output logic                          bus_strobe,
  output logic                          rw,
  output logic      [chain_pkg::SW-1:0] reg_sel,
  output logic      [chain_pkg::DW-1:0] data_in,
  // Answers from the chain
  input  wire logic [chain_pkg::DW-1:0] data_out,
  input  wire logic [chain_pkg::DW-1:0] data_oe,
  input  wire logic                     ready
);
  logic          drv_en;
  logic [DW-1:0] drv_val;

  // Released bits float up through the pull-ups
  assign data_in = (data_oe & data_out) | (~data_oe & (drv_en ? drv_val : ALL_ONES));

  initial begin
    bus_strobe = 1'b0;
    rw         = RW_READ;
    reg_sel    = 4'h0;
    drv_en     = 1'b0;
    drv_val    = 16'h0000;
  end

  // Latency is the count of falling edges that see ready low
  task automatic xfer(input logic rd, input logic [SW-1:0] sel, input logic [DW-1:0] wd,
                      output logic [DW-1:0] rv, output int lat);
    int n;
    n   = 0;
    lat = 0;
    @(negedge sys_clk);
    rw      <= rd;
    reg_sel <= sel;
    drv_en  <= ~rd;
    drv_val <= wd;
    repeat (3) @(negedge sys_clk);
    bus_strobe <= 1'b1;
    while (ready === 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    while (ready !== 1'b1 && lat < 40) begin
      lat++;
      @(negedge sys_clk);
    end
    rv = data_in;
    bus_strobe <= 1'b0;
    @(negedge sys_clk);
    drv_en <= 1'b0;
    rw     <= RW_READ;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic clear_memory();
    logic [DW-1:0] rv;
    int            lat;
    xfer(1'b0, A_STATE, 16'h0010, rv, lat);
    xfer(1'b0, A_BC_LABEL, 16'h0001, rv, lat);
    xfer(1'b0, A_STATE, 16'h0000, rv, lat);
    for (int i = 0; i <= ELEMS; i++) begin
      xfer(1'b0, A_BC_ELEM, 16'h0000, rv, lat);
      xfer(1'b0, A_PTR_GAP, 16'(i), rv, lat);
    end
    xfer(1'b0, A_STATE, 16'h0010, rv, lat);
    xfer(1'b0, A_BC_LABEL, 16'h0000, rv, lat);
    xfer(1'b0, A_STATE, 16'h0000, rv, lat);
  endtask
endmodule

// ### verification/neuron_chain_register_commands_test.sv
/*
  Self-checking bench for the neuron chain register commands.
  Assumes ctrl_model drives the bus and pull-ups hold released lines high.
*/
`timescale 1ns/100ps
module neuron_chain_register_commands_test;
  import chain_pkg::*;
  localparam logic WR = ~RW_READ;
  logic          sys_clk, nrst, bus_strobe, rw, ready;
  logic [SW-1:0] reg_sel;
  logic [DW-1:0] data_in, data_out, data_oe, rv;
  logic          recognized_n_in, recognized_n_out, recognized_n_oe;
  logic          ambiguous_n_in, ambiguous_n_out, ambiguous_n_oe;
  int            err_total, samples_checked, lat;

  // Open-collector status lines with pull-ups
  assign recognized_n_in = recognized_n_oe ? recognized_n_out : 1'b1;
  assign ambiguous_n_in  = ambiguous_n_oe ? ambiguous_n_out : 1'b1;

  always #2 sys_clk = ~sys_clk;

  neuron_chain_register_commands u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .bus_strobe(bus_strobe), .rw(rw), .reg_sel(reg_sel), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .recognized_n_in(recognized_n_in),
    .recognized_n_out(recognized_n_out), .recognized_n_oe(recognized_n_oe),
    .ambiguous_n_in(ambiguous_n_in), .ambiguous_n_out(ambiguous_n_out),
    .ambiguous_n_oe(ambiguous_n_oe), .ready(ready));

  ctrl_model u_ctrl (.sys_clk(sys_clk), .bus_strobe(bus_strobe), .rw(rw), .reg_sel(reg_sel),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ready(ready));

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic op(input logic rd, input logic [SW-1:0] sel, input logic [DW-1:0] wd,
                    input logic [DW-1:0] ev, input int el);
    u_ctrl.xfer(rd, sel, wd, rv, lat);
    if (rd) check(rv, ev, "read data");
    check(16'(lat), 16'(el), "latency");
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic t_defaults();
    logic [SW-1:0] sels [6];
    logic [DW-1:0] vals [6];
    sels = '{A_GLOBAL, A_FLOOR, A_CEIL, A_STATE, A_CONTEXT, A_TALLY};
    vals = '{GLOBAL_DEF, FLOOR_DEF, CEIL_DEF, STATE_DEF, CTX_DEF, 16'h0000};
    check({15'h0000, ready}, 16'h0001, "idle ready");
    for (int i = 0; i < 6; i++)
      op(RW_READ, sels[i], 16'h0000, vals[i], 1);
    $display("test defaults done");
  endtask

  task automatic t_bulk();
    op(WR, A_STATE, 16'h0010, 16'h0000, 1);
    op(WR, A_BC_LABEL, 16'h0005, 16'h0000, 1);
    op(WR, A_REWIND, 16'h0000, 16'h0000, 1);
    op(RW_READ, A_TALLY, 16'h0000, 16'h0001, 1);
    op(WR, A_STATE, 16'h0000, 16'h0000, 1);
    op(RW_READ, A_TALLY, 16'h0000, ALL_ONES, 1);
    op(WR, A_STATE, 16'h0010, 16'h0000, 1);
    op(WR, A_BC_LABEL, 16'h0000, 16'h0000, 1);
    op(WR, A_REWIND, 16'h0000, 16'h0000, 1);
    op(RW_READ, A_TALLY, 16'h0000, 16'h0000, 1);
    op(WR, A_STATE, 16'h0000, 16'h0000, 1);
    $display("test bulk done");
  endtask

  task automatic t_uncommit();
    op(WR, A_STATE, 16'h0010, 16'h0000, 1);
    op(WR, A_BC_LABEL, 16'h0003, 16'h0000, 1);
    op(WR, A_STATE, 16'h0000, 16'h0000, 1);
    op(WR, A_FLOOR, 16'h0033, 16'h0000, 1);
    op(WR, A_CEIL, 16'h1234, 16'h0000, 1);
    op(WR, A_GLOBAL, 16'h0007, 16'h0000, 1);
    op(WR, A_TALLY, 16'h0000, 16'h0000, 1);
    op(RW_READ, A_TALLY, 16'h0000, 16'h0000, 1);
    op(RW_READ, A_FLOOR, 16'h0000, FLOOR_DEF, 1);
    op(RW_READ, A_CEIL, 16'h0000, CEIL_DEF, 1);
    op(RW_READ, A_GLOBAL, 16'h0000, GLOBAL_DEF, 1);
    op(WR, A_FLOAT, 16'h0000, 16'h0000, 1);
    check(data_oe, 16'h0000, "float release");
    $display("test uncommit done");
  endtask

  task automatic t_snoop();
    u_ctrl.clear_memory();
    op(RW_READ, A_TALLY, 16'h0000, 16'h0000, 1);
    op(WR, A_FINAL, 16'h0000, 16'h0000, 1);
    op(WR, A_STATE, 16'h0010, 16'h0000, 1);
    op(WR, A_BC_LABEL, 16'h0001, 16'h0000, 1);
    op(WR, A_STATE, 16'h0000, 16'h0000, 1);
    op(WR, A_FINAL, 16'h0000, 16'h0000, 3);
    check({14'h0000, recognized_n_oe, ambiguous_n_oe}, 16'h0002, "status lines");
    op(RW_READ, A_STATE, 16'h0000, 16'h0008, 1);
    op(RW_READ, A_IDENT, 16'h0000, 16'h0000, 1);
    op(RW_READ, A_PTR_GAP, 16'h0000, 16'h0000, 19);
    // All four tied winners withdrew on the gap read, so no label is left
    op(RW_READ, A_LABEL, 16'h0000, ALL_ONES, 3);
    op(WR, A_LABEL, 16'h0001, 16'h0000, 1);
    op(WR, A_PTR_GAP, 16'h0007, 16'h0000, 1);
    op(WR, A_BC_ELEM, 16'h003c, 16'h0000, 1);
    op(WR, A_STATE, 16'h0010, 16'h0000, 1);
    op(WR, A_REWIND, 16'h0000, 16'h0000, 1);
    op(WR, A_PTR_GAP, 16'h0007, 16'h0000, 1);
    op(RW_READ, A_ELEMENT, 16'h0000, 16'h003c, 1);
    op(WR, A_STATE, 16'h0000, 16'h0000, 1);
    $display("test snoop done");
  endtask

  initial begin
    sys_clk         = 1'b0;
    nrst            = 1'b0;
    err_total       = 0;
    samples_checked = 0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_defaults();
    t_bulk();
    t_uncommit();
    t_snoop();
    conclude();
  end

  // Clear sequence dominates at roughly six thousand cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
